/* src/drp_channel.sv */
`timescale 1ns/1ps
module drp_channel
    import drp_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // pointer port
    drp_ptr_if.chan   port
);
    logic [15:0] stepVal;
    logic [7:0]  nextLow;
    logic [7:0]  nextHigh;
    logic [15:0] next_ptr;
    logic [15:0] next_addr;

    assign stepVal   = port.wordMode ? STEP_WORD : STEP_BYTE;
    assign nextLow   = port.wrLow  ? port.wrData[7:0]  : port.ptr[7:0];
    assign nextHigh  = port.wrHigh ? port.wrData[15:8] : port.ptr[15:8];
    // while active the sequencer owns the pointer; cpu writes fall away
    assign next_ptr  = port.active ? (port.step ? port.ptr + stepVal : port.ptr)
                                   : {nextHigh, nextLow};
    // word accesses ignore bit zero; the stored pointer keeps it for readback
    assign next_addr = port.wordMode ? {next_ptr[15:1], 1'b0} : next_ptr;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            port.ptr     <= PTR_RESET;
            port.ramAddr <= PTR_RESET;
        end else begin
            port.ptr     <= next_ptr;
            port.ramAddr <= next_addr;
        end
    end

    a_byte_step: assert property (
        @(posedge clk_sys) disable iff (reset)
        port.active && port.step && !port.wordMode |=> port.ptr == $past(port.ptr) + STEP_BYTE)
        else $error("byte step not one");

    a_word_step: assert property (
        @(posedge clk_sys) disable iff (reset)
        port.active && port.step && port.wordMode |=> port.ptr == $past(port.ptr) + STEP_WORD)
        else $error("word step not two");

    a_write_blocked: assert property (
        @(posedge clk_sys) disable iff (reset)
        port.active && !port.step ##1 port.active && !port.step |=> port.ptr == $past(port.ptr, 2))
        else $error("pointer moved during transfer without step");

    a_even_word: assert property (
        @(posedge clk_sys) disable iff (reset)
        port.wordMode |=> !port.ramAddr[0])
        else $error("odd address in word mode");

    a_first_addr: assert property (
        @(posedge clk_sys) disable iff (reset)
        $rose(port.active) && !$past(port.wordMode) |-> port.ramAddr == port.ptr)
        else $error("first address differs from pointer");

    a_reset_clear: assert property (
        @(posedge clk_sys)
        reset |=> port.ptr == PTR_RESET)
        else $error("pointer not cleared by reset");

    a_low_byte: assert property (
        @(posedge clk_sys) disable iff (reset)
        !port.active && port.wrLow && !port.wrHigh
        |=> port.ptr == {$past(port.ptr[15:8]), $past(port.wrData[7:0])})
        else $error("low byte write wrong");

    a_high_byte: assert property (
        @(posedge clk_sys) disable iff (reset)
        !port.active && port.wrHigh && !port.wrLow
        |=> port.ptr == {$past(port.wrData[15:8]), $past(port.ptr[7:0])})
        else $error("high byte write wrong");
endmodule // drp_channel

/* src/drp_pkg.sv */
package drp_pkg;
    // geometry
    localparam int          CHANNELS  = 2;
    localparam int          PTR_W     = 16;
    localparam int          ADDR_W    = 22;
    localparam int          DATA_W    = 32;
    localparam int          IDX_W     = 20;

    // register indices; byte address is four times the index
    localparam logic [19:0] IDX_PTR_CH0 = 20'hfffb2;
    localparam logic [19:0] IDX_PTR_CH1 = 20'hfffb4;
    localparam logic [19:0] IDX_MODE    = 20'hfffb6;
    localparam logic [19:0] IDX_STATUS  = 20'hfffb7;
    localparam logic [19:0] PTR_IDX [CHANNELS] = '{IDX_PTR_CH0, IDX_PTR_CH1};

    // field layout of a pointer word: low byte on lane 0, high byte on lane 1
    localparam int          LANE_LOW  = 0;
    localparam int          LANE_HIGH = 1;

    // reset values
    localparam logic [15:0] PTR_RESET  = 16'h0000;
    localparam logic [1:0]  MODE_RESET = 2'h0;

    // increments per transferred unit
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    // bus answers
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

/* src/drp_ptr_if.sv */
`timescale 1ns/1ps
interface drp_ptr_if;
    logic        wrLow;
    logic        wrHigh;
    logic [15:0] wrData;
    logic        wordMode;
    logic        active;
    logic        step;
    logic [15:0] ptr;
    logic [15:0] ramAddr;

    modport host (
        output wrLow, wrHigh, wrData, wordMode, active, step,
        input  ptr, ramAddr
    );
    modport chan (
        input  wrLow, wrHigh, wrData, wordMode, active, step,
        output ptr, ramAddr
    );
endinterface

/* src/drp_top.sv */
// Function
// - each dma channel has a 16-bit pointer naming its ram source or destination.
// - the pointer keeps only the low 16 bits of the ram address.
// - after each unit the pointer steps by one in byte mode, two in word mode.
// - the first ram access uses the pointer value held at transfer start.
// - after the last unit the pointer rests at last address plus step; an odd word-mode pointer keeps bit zero and rests one above.
// - word mode ignores bit zero and accesses an even address.
// - the pointer is read and written as a whole word or separate bytes.
// - reset clears every pointer to zero.
// - channel 0 pointer at fffb2/fffb3, channel 1 at fffb4/fffb5.
// - two independent pointers exist, for channels zero and one.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module drp_top
    import drp_pkg::*;
(
    // clock and reset
    input  wire  logic                      clk_sys,
    input  wire  logic                      reset,
    // axi4-lite write address
    input  wire  logic [ADDR_W-1:0]         s_axi_awaddr,
    input  wire  logic                      s_axi_awvalid,
    output logic                            s_axi_awready,
    // axi4-lite write data
    input  wire  logic [DATA_W-1:0]         s_axi_wdata,
    input  wire  logic [DATA_W/8-1:0]       s_axi_wstrb,
    input  wire  logic                      s_axi_wvalid,
    output logic                            s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire  logic                      s_axi_bready,
    // axi4-lite read address
    input  wire  logic [ADDR_W-1:0]         s_axi_araddr,
    input  wire  logic                      s_axi_arvalid,
    output logic                            s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0]               s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire  logic                      s_axi_rready,
    // transfer sequencer
    input  wire  logic [CHANNELS-1:0]       xferActive,
    input  wire  logic [CHANNELS-1:0]       unitDone,
    output logic [CHANNELS-1:0]             wordMode,
    output logic [CHANNELS*PTR_W-1:0]       ramAddr
);
    logic                  awHeld;
    logic                  wHeld;
    logic [ADDR_W-1:0]     awAddr;
    logic [DATA_W-1:0]     wData;
    logic [DATA_W/8-1:0]   wStrb;
    logic [CHANNELS-1:0]   mode;

    logic                  doWrite;
    logic [IDX_W-1:0]      wIdx;
    logic [IDX_W-1:0]      rIdx;
    logic [CHANNELS-1:0]   wHitPtr;
    logic [CHANNELS-1:0]   rHitPtr;
    logic                  wHitMode;
    logic                  wHitStatus;
    logic                  rHitMode;
    logic                  rHitStatus;
    logic                  wMapped;
    logic                  rMapped;
    logic                  arTake;
    logic [DATA_W-1:0]     rdAcc [CHANNELS+1];
    logic [DATA_W-1:0]     next_rdata;

    drp_ptr_if pif [CHANNELS] ();

    // write waits for both address and data; either may come first
    assign doWrite    = awHeld & wHeld & ~s_axi_bvalid;
    assign wIdx       = awAddr[ADDR_W-1:2];
    assign rIdx       = s_axi_araddr[ADDR_W-1:2];
    assign wHitMode   = (wIdx == IDX_MODE);
    assign wHitStatus = (wIdx == IDX_STATUS);
    assign rHitMode   = (rIdx == IDX_MODE);
    assign rHitStatus = (rIdx == IDX_STATUS);
    assign wMapped    = (|wHitPtr) | wHitMode | wHitStatus;
    assign rMapped    = (|rHitPtr) | rHitMode | rHitStatus;
    assign arTake     = s_axi_arvalid & s_axi_arready;
    assign rdAcc[0]   = rHitMode ? DATA_W'(mode) : (rHitStatus ? DATA_W'(xferActive) : '0);
    assign next_rdata = rdAcc[CHANNELS];

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            assign wHitPtr[c]     = (wIdx == PTR_IDX[c]);
            assign rHitPtr[c]     = (rIdx == PTR_IDX[c]);
            // the active gate inside the channel is what drops blocked writes
            assign pif[c].wrLow    = doWrite & wHitPtr[c] & wStrb[LANE_LOW];
            assign pif[c].wrHigh   = doWrite & wHitPtr[c] & wStrb[LANE_HIGH];
            assign pif[c].wrData   = wData[PTR_W-1:0];
            assign pif[c].wordMode = mode[c];
            assign pif[c].active   = xferActive[c];
            assign pif[c].step     = unitDone[c];
            assign rdAcc[c+1]      = rdAcc[c] | (rHitPtr[c] ? DATA_W'(pif[c].ptr) : '0);
            assign ramAddr[c*PTR_W +: PTR_W] = pif[c].ramAddr;

            drp_channel u_chan (
                .clk_sys (clk_sys),
                .reset   (reset),
                .port    (pif[c])
            );
        end
    endgenerate

    assign wordMode = mode;

    // write address and data capture
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            awHeld        <= 1'b0;
            s_axi_awready <= 1'b1;
            awAddr        <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld        <= 1'b1;
            s_axi_awready <= 1'b0;
            awAddr        <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld        <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wHeld        <= 1'b0;
            s_axi_wready <= 1'b1;
            wData        <= '0;
            wStrb        <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld        <= 1'b1;
            s_axi_wready <= 1'b0;
            wData        <= s_axi_wdata;
            wStrb        <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld        <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // write response; a dropped write still answers okay, the bus has no busy code
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // mode register, lane 0 only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode <= MODE_RESET[CHANNELS-1:0];
        end else if (doWrite && wHitMode && wStrb[LANE_LOW]) begin
            mode <= wData[CHANNELS-1:0];
        end
    end

    // read channel, one cycle from address to data
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (arTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= rMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    a_read_ch0: assert property (
        @(posedge clk_sys) disable iff (reset)
        arTake && s_axi_araddr == {IDX_PTR_CH0, 2'b00}
        |=> s_axi_rvalid && s_axi_rdata == DATA_W'($past(pif[0].ptr)))
        else $error("channel 0 pointer read wrong");

    a_read_ch1: assert property (
        @(posedge clk_sys) disable iff (reset)
        arTake && s_axi_araddr == {IDX_PTR_CH1, 2'b00}
        |=> s_axi_rvalid && s_axi_rdata == DATA_W'($past(pif[1].ptr)))
        else $error("channel 1 pointer read wrong");

    a_blocked_write: assert property (
        @(posedge clk_sys) disable iff (reset)
        doWrite && wHitPtr[0] && xferActive[0] && !unitDone[0]
        |=> pif[0].ptr == $past(pif[0].ptr) && s_axi_bresp == RESP_OKAY)
        else $error("write during transfer changed pointer");

    a_word_write: assert property (
        @(posedge clk_sys) disable iff (reset)
        doWrite && wHitPtr[1] && !xferActive[1] && wStrb[1:0] == 2'h3
        |=> pif[1].ptr == $past(wData[PTR_W-1:0]))
        else $error("word write to channel 1 wrong");

    a_unmapped_err: assert property (
        @(posedge clk_sys) disable iff (reset)
        doWrite && !wMapped |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    a_bvalid_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

    a_rvalid_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");

    a_channels_apart: assert property (
        @(posedge clk_sys) disable iff (reset)
        !xferActive[1] && !pif[1].wrLow && !pif[1].wrHigh && unitDone[0] && xferActive[0]
        |=> pif[1].ptr == $past(pif[1].ptr))
        else $error("channel 1 moved on channel 0 activity");

    a_aw_taken: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready && awHeld)
        else $error("write address not held after take");

    a_w_taken: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_axi_wvalid && s_axi_wready |=> !s_axi_wready && wHeld)
        else $error("write data not held after take");

    a_write_answer: assert property (
        @(posedge clk_sys) disable iff (reset)
        doWrite |=> s_axi_bvalid && !awHeld && !wHeld)
        else $error("write not answered");

    a_b_done: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not reopened");

    a_ar_taken: assert property (
        @(posedge clk_sys) disable iff (reset)
        arTake |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");

    a_r_done: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not reopened");

    a_read_unmapped: assert property (
        @(posedge clk_sys) disable iff (reset)
        arTake && !rMapped |=> s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");

    a_status_read: assert property (
        @(posedge clk_sys) disable iff (reset)
        arTake && rHitStatus |=> s_axi_rdata == DATA_W'($past(xferActive)))
        else $error("status read wrong");

    a_mode_write: assert property (
        @(posedge clk_sys) disable iff (reset)
        doWrite && wHitMode && wStrb[LANE_LOW] |=> wordMode == $past(wData[CHANNELS-1:0]))
        else $error("mode write not stored");

    a_blocked_ch1: assert property (
        @(posedge clk_sys) disable iff (reset)
        doWrite && wHitPtr[1] && xferActive[1] && !unitDone[1]
        |=> pif[1].ptr == $past(pif[1].ptr))
        else $error("write during transfer changed channel 1");

    a_addr_byte0: assert property (
        @(posedge clk_sys) disable iff (reset)
        !mode[0] |=> ramAddr[PTR_W-1:0] == pif[0].ptr)
        else $error("byte mode address differs from pointer");

    a_idle_step: assert property (
        @(posedge clk_sys) disable iff (reset)
        !xferActive[1] && unitDone[1] && !pif[1].wrLow && !pif[1].wrHigh
        |=> pif[1].ptr == $past(pif[1].ptr))
        else $error("pointer stepped outside a transfer");
endmodule // drp_top

/* testbench/drp_seq_model.sv */
`timescale 1ns/1ps
module drp_seq_model
    import drp_pkg::*;
(
    // clock
    input  wire logic            clk_sys,
    // sequencer strobes
    output logic [CHANNELS-1:0]  xferActive,
    output logic [CHANNELS-1:0]  unitDone
);
    initial begin
        xferActive = '0;
        unitDone   = '0;
    end

    // calls start just after a rising edge and return just after one
    task start(input int ch);
        xferActive[ch] <= 1'b1;
        @(posedge clk_sys);
    endtask

    // one pulse per unit; gap 0 gives back-to-back units, the hardest case for the stepper
    task pulse(input int ch, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            unitDone[ch] <= 1'b1;
            @(posedge clk_sys);
            if (gap > 0) begin
                unitDone[ch] <= 1'b0;
                repeat (gap) @(posedge clk_sys);
            end
        end
        if (gap == 0) unitDone[ch] <= 1'b0;
        @(posedge clk_sys);
    endtask

    // software stays off the pointer until this returns, except where a test means otherwise
    task stop(input int ch);
        xferActive[ch] <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule // drp_seq_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_top
    import drp_pkg::*;
;
    localparam logic [ADDR_W-1:0] A_CH0  = {IDX_PTR_CH0, 2'b00};
    localparam logic [ADDR_W-1:0] A_CH1  = {IDX_PTR_CH1, 2'b00};
    localparam logic [ADDR_W-1:0] A_MODE = {IDX_MODE, 2'b00};
    localparam logic [ADDR_W-1:0] A_STAT = {IDX_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] A_BAD  = 22'h000010;

    logic                      clk_sys = 1'b0;
    logic                      reset = 1'b1;
    logic [ADDR_W-1:0]         s_axi_awaddr = '0;
    logic                      s_axi_awvalid = 1'b0;
    logic                      s_axi_awready;
    logic [DATA_W-1:0]         s_axi_wdata = '0;
    logic [DATA_W/8-1:0]       s_axi_wstrb = '0;
    logic                      s_axi_wvalid = 1'b0;
    logic                      s_axi_wready;
    logic [1:0]                s_axi_bresp;
    logic                      s_axi_bvalid;
    logic                      s_axi_bready = 1'b0;
    logic [ADDR_W-1:0]         s_axi_araddr = '0;
    logic                      s_axi_arvalid = 1'b0;
    logic                      s_axi_arready;
    logic [DATA_W-1:0]         s_axi_rdata;
    logic [1:0]                s_axi_rresp;
    logic                      s_axi_rvalid;
    logic                      s_axi_rready = 1'b0;
    logic [CHANNELS-1:0]       xferActive;
    logic [CHANNELS-1:0]       unitDone;
    logic [CHANNELS-1:0]       wordMode;
    logic [CHANNELS*PTR_W-1:0] ramAddr;
    logic [DATA_W-1:0]         rd;
    logic [1:0]                rs;
    int                        n_errors = 0;
    int                        checks_done = 0;

    always #20 clk_sys = ~clk_sys;

    drp_top uut (.clk_sys(clk_sys), .reset(reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .xferActive(xferActive),
        .unitDone(unitDone), .wordMode(wordMode), .ramAddr(ramAddr));

    drp_seq_model seq (.clk_sys(clk_sys), .xferActive(xferActive), .unitDone(unitDone));

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // every bus task is entered just after a rising edge and leaves just after one
    task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [3:0] s,
                            output logic [1:0] r);
        bit ga;
        bit gw;
        bit gb;
        ga = 0;
        gw = 0;
        gb = 0;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {16'h0000, d};
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        while (!(ga && gw)) begin
            @(posedge clk_sys);
            if (!ga && s_axi_awready === 1'b1) begin
                ga = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!gw && s_axi_wready === 1'b1) begin
                gw = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        while (!gb) begin
            @(posedge clk_sys);
            gb = (s_axi_bvalid === 1'b1);
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
        bit gr;
        gr = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        while (s_axi_arready !== 1'b1 || s_axi_arvalid !== 1'b1) @(posedge clk_sys);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        while (!gr) begin
            @(posedge clk_sys);
            gr = (s_axi_rvalid === 1'b1);
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // ram address is looked at mid-cycle, where the design's updates have landed
    task automatic chkAddr(input int ch, input logic [15:0] exp);
        @(negedge clk_sys);
        `CHK(ramAddr[ch*PTR_W +: PTR_W], exp)
        @(posedge clk_sys);
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        axiRead(A_CH0, rd, rs);
        `CHK(rd, 32'h00000000)
        `CHK(rs, RESP_OKAY)
        axiRead(A_CH1, rd, rs);
        `CHK(rd, 32'h00000000)
        chkAddr(0, 16'h0000);
        axiWrite(A_CH0, 16'hf234, 4'h3, rs);
        `CHK(rs, RESP_OKAY)
        axiWrite(A_CH1, 16'hf100, 4'hf, rs);
        axiRead(A_CH0, rd, rs);
        `CHK(rd, 32'h0000f234)
        axiWrite(A_CH1, 16'h0055, 4'h1, rs);
        axiWrite(A_CH1, 16'hf3aa, 4'h2, rs);
        axiRead(A_CH1, rd, rs);
        `CHK(rd, 32'h0000f355)
        axiWrite(A_BAD, 16'h1234, 4'h3, rs);
        `CHK(rs, RESP_SLVERR)
        axiRead(A_BAD, rd, rs);
        `CHK(rs, RESP_SLVERR)
        seq.start(0);
        chkAddr(0, 16'hf234);
        axiRead(A_STAT, rd, rs);
        `CHK(rd, 32'h00000001)
        axiWrite(A_CH0, 16'h1111, 4'h3, rs);
        axiRead(A_CH0, rd, rs);
        `CHK(rd, 32'h0000f234)
        seq.pulse(0, 3, 0);
        seq.pulse(0, 1, 2);
        seq.stop(0);
        axiRead(A_CH0, rd, rs);
        `CHK(rd, 32'h0000f238)
        seq.pulse(1, 2, 0);
        axiRead(A_CH1, rd, rs);
        `CHK(rd, 32'h0000f355)
        axiWrite(A_MODE, 16'h0002, 4'h1, rs);
        `CHK(wordMode, 2'b10)
        axiRead(A_MODE, rd, rs);
        `CHK(rd, 32'h00000002)
        chkAddr(1, 16'hf354);
        chkAddr(0, 16'hf238);
        seq.start(1);
        axiWrite(A_CH1, 16'hef00, 4'h3, rs);
        `CHK(rs, RESP_OKAY)
        seq.pulse(1, 2, 1);
        seq.stop(1);
        axiRead(A_CH1, rd, rs);
        `CHK(rd, 32'h0000f359)
        chkAddr(1, 16'hf358);
        axiRead(A_CH0, rd, rs);
        `CHK(rd, 32'h0000f238)
        // a second reset with loaded pointers and word mode set
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        axiRead(A_CH0, rd, rs);
        `CHK(rd, 32'h00000000)
        `CHK(wordMode, 2'b00)
        chkAddr(1, 16'h0000);
        results();
    end

    // the tests take well under a thousand cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        results();
    end
endmodule // tb_top
